// *** design/spf_pkg.sv ***
/*
 * Shared constants for the serial memory command front end: opcodes,
 * status layout, address width and link timing.
 * Assumes both link ends and the bench import this package.
 */
package spf_pkg;
    // Command opcodes
    localparam logic [7:0] OP_SET_LATCH = 8'h06;
    localparam logic [7:0] OP_CLR_LATCH = 8'h04;
    localparam logic [7:0] OP_STAT_RD   = 8'h05;
    localparam logic [7:0] OP_STAT_WR   = 8'h01;
    localparam logic [7:0] OP_MEM_RD    = 8'h03;
    localparam logic [7:0] OP_QUICK_RD  = 8'h0b;
    localparam logic [7:0] OP_MEM_WR    = 8'h02;
    localparam logic [7:0] OP_SLEEP     = 8'hb9;
    localparam logic [7:0] OP_IDENT_RD  = 8'h9f;
    // Status byte layout
    localparam int         STAT_LATCH_BIT = 1;
    localparam logic [7:0] STAT_WR_MASK   = 8'h8c;
    localparam logic [7:0] STAT_FIXED     = 8'h40;
    localparam logic [7:0] STAT_CFG_RESET = 8'h00;
    // Address handling
    localparam int         ADDR_W       = 18;
    localparam logic [1:0] ADDR_LAST    = 2'h2;
    // Link timing
    localparam int         CLK_PERIOD_NS = 40;
    localparam int         SCK_PERIOD_NS = 320;
    localparam int         SCK_HALF_CYC  = (SCK_PERIOD_NS / (2 * CLK_PERIOD_NS) < 1) ? 1 :
                                           SCK_PERIOD_NS / (2 * CLK_PERIOD_NS);

    // One of the nine known opcodes
    function automatic logic op_valid(input logic [7:0] op);
        case (op)
            OP_SET_LATCH, OP_CLR_LATCH, OP_STAT_RD, OP_STAT_WR, OP_MEM_RD,
            OP_QUICK_RD, OP_MEM_WR, OP_SLEEP, OP_IDENT_RD: op_valid = 1'b1;
            default: op_valid = 1'b0;
        endcase
    endfunction

    // Opcodes that carry a three byte address
    function automatic logic op_has_addr(input logic [7:0] op);
        op_has_addr = (op == OP_MEM_RD) || (op == OP_QUICK_RD) || (op == OP_MEM_WR);
    endfunction
endpackage

// *** design/spf_if.sv ***
/*
 * Link between the memory front end and its controller.
 * Assumes the bench resolves the output line from miso_oe.
 */
`timescale 1ns/10ps
interface spf_if;
    logic sck;      // Serial clock from the controller
    logic cs_n;     // Chip select, active low
    logic mosi;     // Controller to device data
    logic miso;     // Device to controller data
    logic miso_oe;  // Device drives miso while high

    // Device end
    modport dev (input sck, input cs_n, input mosi, output miso, output miso_oe);
    // Controller end
    modport ctl (output sck, output cs_n, output mosi, input miso);
endinterface

// *** design/spf_sync.sv ***
/*
 * Two flip-flop synchroniser for a group of link levels.
 * Assumes each bit is a level from outside the i_clk domain.
 */
`timescale 1ns/10ps
module spf_sync #(
    parameter int           W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         i_clk,
    input  wire logic         i_arst_n,
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    logic [W-1:0] meta;  // First stage, read only by second stage

    // Two stages per bit
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            meta <= RST;
            o_q  <= RST;
        end else begin
            meta <= i_d;
            o_q  <= meta;
        end
    end
endmodule

// *** design/spf_ctl.sv ***
/*
 * Controller end: makes the serial clock by division, frames one command
 * per select period and shifts bytes out and in, top bit first.
 * Assumes the user offers the next byte on i_tx_data when o_tx_take pulses.
 */
`timescale 1ns/10ps
module spf_ctl
(
    input  wire logic       i_clk,
    input  wire logic       i_arst_n,
    spf_if.ctl              bus,
    input  wire logic       i_start,
    input  wire logic       i_mode3,
    input  wire logic [7:0] i_nbytes,
    input  wire logic [7:0] i_tx_data,
    output logic            o_tx_take,
    output logic [7:0]      o_rx_data,
    output logic            o_rx_valid,
    output logic            o_busy
);
    import spf_pkg::*;
    typedef enum logic [4:0] {
        M_IDLE = 5'b00001,
        M_SEL  = 5'b00010,
        M_LOW  = 5'b00100,
        M_HIGH = 5'b01000,
        M_END  = 5'b10000
    } spf_mstate_t;

    spf_mstate_t state;       // Frame sequencer
    logic [7:0]  div;         // Half period counter
    logic        half_done;   // Half period elapsed
    logic [2:0]  bit_cnt;     // Bit inside byte
    logic [7:0]  left;        // Bytes still to send
    logic [7:0]  tx_sh;       // Outgoing byte
    logic [7:0]  rx_sh;       // Incoming byte
    logic        mode3;       // Idle clock level of this frame
    logic        miso_s;      // Synchronised return data

    assign half_done = (div == 8'(SCK_HALF_CYC - 1));

    spf_sync #(.W(1), .RST(1'b0)) u_miso_sync (
        .i_clk    (i_clk),
        .i_arst_n (i_arst_n),
        .i_d      (bus.miso),
        .o_q      (miso_s)
    );

    // Divider restarts on every phase change
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            div <= 8'h00;
        end else if (state == M_IDLE || half_done) begin
            div <= 8'h00;
        end else begin
            div <= div + 8'h01;
        end
    end

    // Frame sequencer with clock, select and data lines
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state      <= M_IDLE;
            bus.sck    <= 1'b0;
            bus.cs_n   <= 1'b1;
            bus.mosi   <= 1'b0;
            mode3      <= 1'b0;
            bit_cnt    <= 3'h0;
            left       <= 8'h00;
            tx_sh      <= 8'h00;
            rx_sh      <= 8'h00;
            o_tx_take  <= 1'b0;
            o_rx_data  <= 8'h00;
            o_rx_valid <= 1'b0;
            o_busy     <= 1'b0;
        end else begin
            o_tx_take  <= 1'b0;
            o_rx_valid <= 1'b0;
            case (state)
                M_IDLE: begin
                    bus.sck <= i_mode3;
                    if (i_start && i_nbytes != 8'h00) begin
                        bus.cs_n  <= 1'b0;
                        mode3     <= i_mode3;
                        left      <= i_nbytes;
                        tx_sh     <= i_tx_data;
                        o_tx_take <= 1'b1;
                        bit_cnt   <= 3'h0;
                        o_busy    <= 1'b1;
                        state     <= M_SEL;
                    end
                end
                M_SEL: begin
                    // Clock held at idle level so the device sees the mode
                    if (half_done) begin
                        bus.sck  <= 1'b0;
                        bus.mosi <= tx_sh[7];
                        state    <= M_LOW;
                    end
                end
                M_LOW: begin
                    if (half_done) begin
                        bus.sck <= 1'b1;
                        state   <= M_HIGH;
                    end
                end
                M_HIGH: begin
                    if (half_done) begin
                        rx_sh   <= {rx_sh[6:0], miso_s};
                        bit_cnt <= bit_cnt + 3'h1;
                        if (bit_cnt == 3'h7) begin
                            o_rx_data  <= {rx_sh[6:0], miso_s};
                            o_rx_valid <= 1'b1;
                        end
                        if (bit_cnt == 3'h7 && left == 8'h01) begin
                            bus.sck <= mode3;
                            state   <= M_END;
                        end else if (bit_cnt == 3'h7) begin
                            left      <= left - 8'h01;
                            tx_sh     <= i_tx_data;
                            o_tx_take <= 1'b1;
                            bus.mosi  <= i_tx_data[7];
                            bus.sck   <= 1'b0;
                            state     <= M_LOW;
                        end else begin
                            tx_sh    <= {tx_sh[6:0], 1'b0};
                            bus.mosi <= tx_sh[6];
                            bus.sck  <= 1'b0;
                            state    <= M_LOW;
                        end
                    end
                end
                M_END: begin
                    // Select released after a quiet half period
                    if (half_done) begin
                        bus.cs_n <= 1'b1;
                        o_busy   <= 1'b0;
                        state    <= M_IDLE;
                    end
                end
                default: begin
                    state <= M_IDLE;
                end
            endcase
        end
    end
endmodule

// *** design/spf_dev.sv ***
/*
 * Device end: select framing, mode detection, opcode capture and decode,
 * address capture, write latch and status byte, serial return data.
 * Assumes i_clk is much faster than the serial clock (at least 8x) and
 * that i_rd_data holds the byte at o_addr whenever read data is fetched.
 */
`timescale 1ns/10ps
module spf_dev
(
    input  wire logic              i_clk,
    input  wire logic              i_arst_n,
    spf_if.dev                     bus,
    input  wire logic [7:0]        i_rd_data,
    output logic [7:0]             o_opcode,
    output logic                   o_cmd_valid,
    output logic                   o_cmd_invalid,
    output logic                   o_mode3,
    output logic                   o_write_latch,
    output logic [7:0]             o_status,
    output logic [spf_pkg::ADDR_W-1:0] o_addr,
    output logic [7:0]             o_wr_data,
    output logic                   o_wr_valid,
    output logic                   o_rd_req
);
    import spf_pkg::*;
    typedef enum logic [5:0] {
        S_IDLE   = 6'b000001,
        S_OPC    = 6'b000010,
        S_ADDR   = 6'b000100,
        S_DUMMY  = 6'b001000,
        S_DATA   = 6'b010000,
        S_IGNORE = 6'b100000
    } spf_dstate_t;

    spf_dstate_t     state;      // Command sequencer
    logic [2:0]      sync_q;     // Synchronised sck, cs_n, mosi
    logic            sck_s;      // Synchronised clock
    logic            cs_s;       // Synchronised select
    logic            mosi_s;     // Synchronised data in
    logic            sck_d;      // Clock one cycle back
    logic            cs_d;       // Select one cycle back
    logic            sck_rise;   // Sampling edge while selected
    logic            sck_fall;   // Output edge while selected
    logic            cs_fall;    // Frame start
    logic            cs_rise;    // Frame end
    logic [2:0]      bit_cnt;    // Bit inside current byte
    logic [1:0]      addr_cnt;   // Address byte count
    logic [7:0]      rx_sh;      // Incoming bits
    logic [7:0]      rx_byte;    // Byte completed this edge
    logic            byte_done;  // Eighth rise of a byte
    logic            op_ok;      // A valid opcode was taken this frame
    logic            latch;      // Write enable latch
    logic [7:0]      sr_cfg;     // Writable status bits
    logic [7:0]      stat_byte;  // Status as read back
    logic [7:0]      tx_sh;      // Outgoing bits
    logic            tx_on;      // Command returns data
    logic            rd_mem;     // Command reads the array
    logic [ADDR_W-1:0] addr;     // Address counter

    spf_sync #(.W(3), .RST(3'b010)) u_link_sync (
        .i_clk    (i_clk),
        .i_arst_n (i_arst_n),
        .i_d      ({bus.sck, bus.cs_n, bus.mosi}),
        .o_q      (sync_q)
    );

    assign sck_s     = sync_q[2];
    assign cs_s      = sync_q[1];
    assign mosi_s    = sync_q[0];
    // Edges counted only while selected; in mode 3 the first rise
    // only appears after the clock has dropped once
    assign sck_rise  = sck_s & ~sck_d & ~cs_s;
    assign sck_fall  = ~sck_s & sck_d & ~cs_s;
    assign cs_fall   = cs_d & ~cs_s;
    assign cs_rise   = ~cs_d & cs_s;
    assign byte_done = sck_rise && (bit_cnt == 3'h7);
    assign rx_byte   = {rx_sh[6:0], mosi_s};
    // Status byte: fixed bits, writable bits and latch flag
    assign stat_byte = STAT_FIXED | (sr_cfg & STAT_WR_MASK) |
                       (8'({latch}) << STAT_LATCH_BIT);
    assign rd_mem    = (o_opcode == OP_MEM_RD) || (o_opcode == OP_QUICK_RD);
    assign tx_on     = op_ok && (rd_mem || o_opcode == OP_STAT_RD);

    // Edge history
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sck_d <= 1'b0;
            cs_d  <= 1'b1;
        end else begin
            sck_d <= sck_s;
            cs_d  <= cs_s;
        end
    end

    // Mode taken from the clock level at the select edge
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_mode3 <= 1'b0;
        end else if (cs_fall) begin
            o_mode3 <= sck_s;
        end
    end

    // Bit shifting and counting on sampling edges
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            bit_cnt <= 3'h0;
            rx_sh   <= 8'h00;
        end else if (cs_fall) begin
            bit_cnt <= 3'h0;
        end else if (sck_rise && state != S_IGNORE) begin
            bit_cnt <= bit_cnt + 3'h1;
            rx_sh   <= rx_byte;
        end
    end

    // Command sequencer
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state <= S_IDLE;
        end else if (cs_s) begin
            state <= S_IDLE;
        end else if (cs_fall) begin
            state <= S_OPC;
        end else if (byte_done) begin
            case (state)
                S_OPC: begin
                    if (!op_valid(rx_byte)) begin
                        state <= S_IGNORE;
                    end else if (op_has_addr(rx_byte)) begin
                        state <= S_ADDR;
                    end else begin
                        state <= S_DATA;
                    end
                end
                S_ADDR: begin
                    if (addr_cnt == ADDR_LAST) begin
                        state <= (o_opcode == OP_QUICK_RD) ? S_DUMMY : S_DATA;
                    end
                end
                S_DUMMY: begin
                    state <= S_DATA;
                end
                S_DATA: begin
                    // Status write takes one byte only
                    if (o_opcode == OP_STAT_WR) begin
                        state <= S_IGNORE;
                    end
                end
                default: begin
                    state <= state;
                end
            endcase
        end
    end

    // Opcode capture and decode pulses
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_opcode      <= 8'h00;
            op_ok         <= 1'b0;
            o_cmd_valid   <= 1'b0;
            o_cmd_invalid <= 1'b0;
        end else begin
            o_cmd_valid   <= 1'b0;
            o_cmd_invalid <= 1'b0;
            if (cs_fall) begin
                op_ok <= 1'b0;
            end else if (byte_done && state == S_OPC) begin
                o_opcode      <= rx_byte;
                op_ok         <= op_valid(rx_byte);
                o_cmd_valid   <= op_valid(rx_byte);
                o_cmd_invalid <= ~op_valid(rx_byte);
            end
        end
    end

    // Write latch: set by its command, cleared when a clear, status write or memory write frame ends
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            latch <= 1'b0;
        end else if (cs_rise && op_ok && (o_opcode == OP_CLR_LATCH ||
                     o_opcode == OP_STAT_WR || o_opcode == OP_MEM_WR)) begin
            latch <= 1'b0;
        end else if (byte_done && state == S_OPC && rx_byte == OP_SET_LATCH) begin
            latch <= 1'b1;
        end
    end

    // Status write keeps only the writable bits, never the latch flag
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sr_cfg <= STAT_CFG_RESET;
        end else if (byte_done && state == S_DATA && o_opcode == OP_STAT_WR && latch) begin
            sr_cfg <= rx_byte & STAT_WR_MASK;
        end
    end

    // Address capture, memory writes and read address stepping
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            addr       <= '0;
            addr_cnt   <= 2'h0;
            o_wr_data  <= 8'h00;
            o_wr_valid <= 1'b0;
        end else begin
            o_wr_valid <= 1'b0;
            if (cs_fall) begin
                addr_cnt <= 2'h0;
            end else if (byte_done && state == S_ADDR) begin
                // Older bits fall off the top, leaving the last 18
                addr     <= {addr[ADDR_W-9:0], rx_byte};
                addr_cnt <= addr_cnt + 2'h1;
            end else if (byte_done && state == S_DATA && o_opcode == OP_MEM_WR && latch) begin
                o_wr_data  <= rx_byte;
                o_wr_valid <= 1'b1;
            end else if (o_wr_valid) begin
                addr <= addr + 1'b1;
            end else if (sck_fall && state == S_DATA && rd_mem && bit_cnt == 3'h0) begin
                addr <= addr + 1'b1;
            end
        end
    end

    // Return data changes on falling edges, driven only while selected
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            tx_sh       <= 8'h00;
            bus.miso    <= 1'b0;
            bus.miso_oe <= 1'b0;
            o_rd_req    <= 1'b0;
        end else begin
            o_rd_req <= 1'b0;
            if (cs_s) begin
                bus.miso_oe <= 1'b0;
            end else if (sck_fall && state == S_DATA && tx_on) begin
                bus.miso_oe <= 1'b1;
                if (bit_cnt == 3'h0) begin
                    // Byte boundary: fetch status or array byte
                    tx_sh    <= {(rd_mem ? i_rd_data[6:0] : stat_byte[6:0]), 1'b0};
                    bus.miso <= rd_mem ? i_rd_data[7] : stat_byte[7];
                    o_rd_req <= rd_mem;
                end else begin
                    tx_sh    <= {tx_sh[6:0], 1'b0};
                    bus.miso <= tx_sh[7];
                end
            end
        end
    end

    // Registered user view
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_write_latch <= 1'b0;
            o_status      <= STAT_FIXED;
            o_addr        <= '0;
        end else begin
            o_write_latch <= latch;
            o_status      <= stat_byte;
            o_addr        <= addr;
        end
    end
endmodule

// *** testbench/spf_chk.sv ***
/*
 * Link checker for the serial memory command front end.
 * Assumes it watches the link that joins the controller and device ends.
 */
`timescale 1ns/10ps
module spf_chk
(
    input  wire logic i_clk,
    input  wire logic i_arst_n,
    input  wire logic sck,
    input  wire logic cs_n,
    input  wire logic mosi,
    input  wire logic miso,
    input  wire logic miso_oe
);
    import spf_pkg::*;
    logic       sck_q;  // Serial clock one cycle back
    logic [7:0] cnt;    // Clock rises seen in this frame
    logic [7:0] op;     // First byte of this frame
    logic       rd_op;  // Opcode that returns data
    logic       known;  // Opcode is one of the nine

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);

    assign rd_op = op inside {OP_STAT_RD, OP_MEM_RD, OP_QUICK_RD};
    assign known = rd_op || (op inside {OP_SET_LATCH, OP_CLR_LATCH, OP_STAT_WR,
                                        OP_MEM_WR, OP_SLEEP, OP_IDENT_RD});

    // Count rises and gather the opcode while selected
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sck_q <= 1'b0;
            cnt   <= 8'h00;
            op    <= 8'h00;
        end else begin
            sck_q <= sck;
            if (cs_n) begin
                cnt <= 8'h00;
                op  <= 8'h00;
            end else if (sck && !sck_q) begin
                cnt <= cnt + 8'h01;
                if (cnt < 8'h08) op <= {op[6:0], mosi};
            end
        end
    end

    property p_desel_quiet;
        cs_n [*6] |-> !miso_oe;
    endproperty
    a_desel_quiet: assert property (p_desel_quiet)
        else $error("output driven while deselected");
    property p_opcode_quiet;
        !cs_n && cnt < 8'h08 |-> !miso_oe;
    endproperty
    a_opcode_quiet: assert property (p_opcode_quiet)
        else $error("output driven during opcode byte");
    property p_no_data_quiet;
        !cs_n && cnt >= 8'h08 && !rd_op |-> !miso_oe;
    endproperty
    a_no_data_quiet: assert property (p_no_data_quiet)
        else $error("output driven for a command without return data");
    property p_status_drive;
        !cs_n && cnt == 8'h08 && $past(cnt) == 8'h07 && op == OP_STAT_RD
            |-> ##[2:12] miso_oe;
    endproperty
    a_status_drive: assert property (p_status_drive)
        else $error("status byte not driven");
    property p_miso_steady;
        !cs_n && !$past(cs_n) && sck && $past(sck) |-> $stable(miso);
    endproperty
    a_miso_steady: assert property (p_miso_steady)
        else $error("return data moved while clock high");
    property p_mosi_steady;
        !cs_n && !$past(cs_n) && sck && $past(sck) |-> $stable(mosi);
    endproperty
    a_mosi_steady: assert property (p_mosi_steady)
        else $error("input data moved while clock high");
    property p_select_still;
        $fell(cs_n) |-> $stable(sck) [*3];
    endproperty
    a_select_still: assert property (p_select_still)
        else $error("clock moved at select");
    property p_whole_bytes;
        $rose(cs_n) |-> cnt != 8'h00 && cnt[2:0] == 3'h0;
    endproperty
    a_whole_bytes: assert property (p_whole_bytes)
        else $error("frame not a whole number of bytes");

    c_status_read: cover property (cnt == 8'h08 && op == OP_STAT_RD);
    c_bad_op: cover property (cnt == 8'h08 && !known);
    c_mode3: cover property ($fell(cs_n) && sck);
endmodule

// *** testbench/spi_slave_command_frontend_test.sv ***
/*
 * Self-checking bench: controller and device joined by one link, and a
 * second device driven by hand for cut-short and whole frames.
 * Assumes the package, link and both design ends are compiled first.
 */
`timescale 1ns/10ps
module spi_slave_command_frontend_test;
    import spf_pkg::*;
    typedef struct packed {
        logic m3; logic [2:0] n; logic [47:0] b; logic latch;
        logic [7:0] stat; logic bad; logic chk; logic [7:0] rx;
    } spf_row_t;
    // Frames sent through the controller and the state each leaves behind
    spf_row_t rows [15] = '{
        '{0, 1, 48'h060000000000, 1, 8'h42, 0, 0, 8'h00},
        '{1, 1, 48'h040000000000, 0, 8'h40, 0, 0, 8'h00},
        '{1, 2, 48'h01ff00000000, 0, 8'h40, 0, 0, 8'h00},
        '{0, 5, 48'h020000053300, 0, 8'h40, 0, 0, 8'h00},
        '{0, 2, 48'h550600000000, 0, 8'h40, 1, 0, 8'h00},
        '{0, 1, 48'h060000000000, 1, 8'h42, 0, 0, 8'h00},
        '{0, 1, 48'hb90000000000, 1, 8'h42, 0, 0, 8'h00},
        '{1, 1, 48'h9f0000000000, 1, 8'h42, 0, 0, 8'h00},
        '{1, 2, 48'h050000000000, 1, 8'h42, 0, 1, 8'h42},
        '{0, 2, 48'h01ff00000000, 0, 8'hcc, 0, 0, 8'h00},
        '{1, 2, 48'h050000000000, 0, 8'hcc, 0, 1, 8'hcc},
        '{0, 1, 48'h060000000000, 1, 8'hce, 0, 0, 8'h00},
        '{1, 5, 48'h02fc0001a700, 0, 8'hcc, 0, 0, 8'h00},
        '{0, 5, 48'h030000100000, 0, 8'hcc, 0, 1, 8'h4a},
        '{1, 6, 48'h0b03ffff0000, 0, 8'hcc, 0, 1, 8'ha5}};
    logic clk = 1'b0, arst_n = 1'b0, start = 1'b0, mode3 = 1'b0;  // Drives
    logic [7:0] nbytes = 8'h00;      // Frame length
    logic [47:0] txq = '0;           // Bytes still to send, next on top
    logic tx_take, rx_valid, busy, ok, bad, mode, latch, wr_valid, rd_req;  // Pulses, levels
    logic ok2, mode2, latch2;        // Hand-driven device outputs
    logic seen_ok, seen_bad, seen2;  // Sticky pulse flags
    logic [7:0] rx_data, last_rx, status, opcode, wr_data, wr_byte;
    logic [ADDR_W-1:0] addr, wr_addr;  // Address now and at last write
    int n_fail = 0, n_tests = 0, n_wr = 0, n_rd = 0;
    spf_if l1 ();
    spf_if l2 ();
    spf_ctl spf_ctl_inst (.i_clk(clk), .i_arst_n(arst_n), .bus(l1.ctl), .i_start(start),
        .i_mode3(mode3), .i_nbytes(nbytes), .i_tx_data(txq[47:40]), .o_tx_take(tx_take),
        .o_rx_data(rx_data), .o_rx_valid(rx_valid), .o_busy(busy));
    spf_dev spf_dev_inst (.i_clk(clk), .i_arst_n(arst_n), .bus(l1.dev),
        .i_rd_data(addr[7:0] ^ 8'h5a), .o_opcode(opcode), .o_cmd_valid(ok),
        .o_cmd_invalid(bad), .o_mode3(mode), .o_write_latch(latch), .o_status(status),
        .o_addr(addr), .o_wr_data(wr_data), .o_wr_valid(wr_valid), .o_rd_req(rd_req));
    spf_dev spf_dev_inst_b (.i_clk(clk), .i_arst_n(arst_n), .bus(l2.dev), .i_rd_data(8'h00),
        .o_opcode(), .o_cmd_valid(ok2), .o_cmd_invalid(), .o_mode3(mode2),
        .o_write_latch(latch2), .o_status(), .o_addr(), .o_wr_data(), .o_wr_valid(),
        .o_rd_req());
    spf_chk spf_chk_inst (.i_clk(clk), .i_arst_n(arst_n), .sck(l1.sck), .cs_n(l1.cs_n),
        .mosi(l1.mosi), .miso(l1.miso), .miso_oe(l1.miso_oe));

    always #20 clk = ~clk;

    // Feed bytes on demand and record what the ends report
    always @(posedge clk) begin
        if (tx_take) txq <= txq << 8;
        if (rx_valid) last_rx <= rx_data;
        if (ok) seen_ok <= 1'b1;
        if (bad) seen_bad <= 1'b1;
        if (ok2) seen2 <= 1'b1;
        if (wr_valid) n_wr <= n_wr + 1;
        if (wr_valid) wr_byte <= wr_data;
        if (wr_valid) wr_addr <= addr;
        if (rd_req) n_rd <= n_rd + 1;
    end

    task automatic check(input logic [47:0] seen, input logic [47:0] want);
        n_tests++;
        if (seen !== want) begin
            n_fail++;
            $display("unexpected at %0t: seen %0h want %0h", $time, seen, want);
        end
    endtask

    // One frame through the controller, then a quiet gap
    task automatic frame(input logic m, input logic [2:0] n, input logic [47:0] b);
        int k;
        @(posedge clk);
        mode3 <= m;
        txq <= b;
        nbytes <= {5'h00, n};
        seen_ok <= 1'b0;
        seen_bad <= 1'b0;
        repeat (12) @(posedge clk);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        repeat (2) @(posedge clk);
        for (k = 0; k < 3000 && busy !== 1'b0; k++)
            @(posedge clk);
        if (k == 3000) n_fail++;
        repeat (10) @(posedge clk);
    endtask

    // Hand-made frame on the second link, possibly cut short
    task automatic bang(input logic m, input logic [7:0] b, input int nb);
        seen2 <= 1'b0;
        l2.sck <= m;
        repeat (8) @(posedge clk);
        l2.cs_n <= 1'b0;
        for (int i = 0; i < nb; i++) begin
            repeat (4) @(posedge clk);
            l2.sck <= 1'b0;
            l2.mosi <= b[7 - i];
            repeat (4) @(posedge clk);
            l2.sck <= 1'b1;
        end
        repeat (4) @(posedge clk);
        l2.sck <= m;
        repeat (4) @(posedge clk);
        l2.cs_n <= 1'b1;
        l2.mosi <= ~l2.mosi;
        repeat (10) @(posedge clk);
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Watchdog far beyond the expected run
    initial begin
        #2000000;
        n_fail++;
        tally_and_finish();
    end

    initial begin
        l2.sck = 1'b0;
        l2.cs_n = 1'b1;
        l2.mosi = 1'b0;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        foreach (rows[i]) begin
            frame(rows[i].m3, rows[i].n, rows[i].b);
            check(latch, rows[i].latch);
            check(status, rows[i].stat);
            check(seen_bad, rows[i].bad);
            check(seen_ok, !rows[i].bad);
            check(opcode, rows[i].b[47:40]);
            check(mode, rows[i].m3);
            if (rows[i].chk) check(last_rx, rows[i].rx);
            $display("row %0d finished", i);
        end
        check(n_wr, 1);
        check(wr_byte, 8'ha7);
        check(wr_addr, 18'h00001);
        check(n_rd, 3);
        $display("write capture finished");
        bang(1'b1, OP_SET_LATCH, 4);
        check({latch2, seen2}, 2'b00);
        bang(1'b0, OP_SET_LATCH, 8);
        check({latch2, seen2, mode2}, 3'b110);
        $display("hand frames finished");
        frame(1'b0, 3'h1, 48'h060000000000);
        arst_n <= 1'b0;
        repeat (3) @(posedge clk);
        check({latch, status}, 9'h040);
        arst_n <= 1'b1;
        $display("reset finished");
        tally_and_finish();
    end
endmodule
